// File: sdcd_mem.sv
`timescale 1ns/1ps
module sdcd_mem
    import sdcd_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    // Command pins
    sdcd_if.mem                    pins,
    // Decoded command
    output sdcd_cmd_t              cmd,
    output logic [BANK_W-1:0]      cmd_bank,
    output logic [ADDR_W-1:0]      cmd_addr,
    output logic                   all_rows_close_cmd,
    output logic                   long_impedance_cal,
    output logic                   auto_close_flag,
    output logic                   chopped_four_burst,
    // Status
    output sdcd_pwr_t              pwr_state,
    output logic                   burst_busy,
    output logic                   burst_close,
    output logic                   termination_on,
    output logic [OP_W-1:0]        mode_reg0
);
    // Synchronised pins, two stages each
    localparam int PW = 7 + BANK_W + ADDR_W;
    // Idle pin levels, so no false clock enable edge follows reset
    localparam logic [PW-1:0] PIN_IDLE = {1'b0, 1'b1, 1'b1, 1'b0, CODE_IDLE, {(BANK_W + ADDR_W){1'b0}}};
    logic [PW-1:0] p_raw;
    assign p_raw = {pins.termination_control, pins.rst_n, pins.cke, pins.cs_n,
                    pins.ras_n, pins.cas_n, pins.we_n, pins.bank, pins.addr};

    // All state
    typedef struct packed {
        logic [PW-1:0]     m1;       // First stage, read only by second
        logic [PW-1:0]     m2;       // Second stage
        logic              cke_prev; // Clock enable at previous edge
        sdcd_pwr_t         pwr;      // Power state
        sdcd_cmd_t         cmd;      // Decoded command
        logic [BANK_W-1:0] bank;     // Command bank
        logic [ADDR_W-1:0] addr;     // Command address
        logic              allc;     // All-bank close
        logic              lcal;     // Long calibration
        logic              ac;       // Auto close
        logic              chop;     // Four-beat burst
        logic              term;     // Termination active
        logic [OP_W-1:0]   mr0;      // Mode register 0
    } sdcd_mem_st_t;

    sdcd_mem_st_t s_q, s_d;

    // Decoded pin fields
    logic              p_term, p_rst_n, p_cke, p_cs_n;
    logic [2:0]        p_code;
    logic [BANK_W-1:0] p_bank;
    logic [ADDR_W-1:0] p_addr;
    logic              b_start, b_busy, b_close;
    logic [2:0]        b_len;

    assign {p_term, p_rst_n, p_cke, p_cs_n, p_code, p_bank, p_addr} = s_q.m2;

    // Strobe code, select high counts as idle
    function automatic logic [2:0] strobe_code(input logic cs_n, input logic [2:0] code);
        strobe_code = cs_n ? CODE_IDLE : code;
    endfunction

    // Burst length per mode and A12
    function automatic logic [2:0] burst_len(input logic [OP_W-1:0] mr, input logic a12);
        if (mr[OTF_SEL_LO +: 2] == BURST_OTF) begin
            burst_len = a12 ? BEATS8_CYC : BEATS4_CYC;
        end else begin
            burst_len = (mr[OTF_SEL_LO +: 2] == BURST_FIX4) ? BEATS4_CYC : BEATS8_CYC;
        end
    endfunction

    // Burst runner
    sdcd_burst u_burst (
        .mclk        (mclk),
        .sys_rst     (sys_rst),
        .start       (b_start),
        .len_cyc     (b_len),
        .auto_close  (p_addr[AUTO_CLOSE_BIT]),
        .busy        (b_busy),
        .close_pulse (b_close)
    );

    // Next state: decode from sampled pins only
    always_comb begin
        logic [2:0] code;
        code    = strobe_code(p_cs_n, p_code);
        s_d     = s_q;
        s_d.m1  = p_raw;
        s_d.m2  = s_q.m1;
        s_d.cke_prev = p_cke;
        s_d.cmd = SDCD_NONE;
        s_d.bank = p_bank;
        s_d.addr = p_addr;
        b_start = 1'b0;
        b_len   = burst_len(s_q.mr0, p_addr[BURST_CHOP_BIT]);
        unique case (s_q.pwr)
            SDCD_SELF: begin
                // An edge with clock enable high and an idle or deselect code leaves
                if (p_cke && code == CODE_IDLE) begin
                    s_d.pwr = SDCD_AWAKE;
                    s_d.cmd = SDCD_SRX;
                end
            end
            SDCD_SLEEP: begin
                // No refresh while asleep
                if (p_cke && code == CODE_IDLE) begin
                    s_d.pwr = SDCD_AWAKE;
                    s_d.cmd = SDCD_SLPOUT;
                end
            end
            SDCD_AWAKE: begin
                if (s_q.cke_prev && !p_cke) begin
                    // Clock enable falling
                    if (code == CODE_RECHG) begin
                        s_d.pwr = SDCD_SELF;
                        s_d.cmd = SDCD_SRE;
                    end else if (code == CODE_IDLE) begin
                        s_d.pwr = SDCD_SLEEP;
                        s_d.cmd = SDCD_SLPIN;
                    end
                end else if (s_q.cke_prev && p_cke) begin
                    unique case (code)
                        CODE_LOAD: begin
                            s_d.cmd = SDCD_LOAD;
                            if (p_bank == MODE_REG0) begin
                                s_d.mr0 = OP_W'(p_addr);
                            end
                        end
                        CODE_RECHG: s_d.cmd = SDCD_RECHG;
                        CODE_CLOSE: begin
                            s_d.cmd  = SDCD_CLOSE;
                            s_d.allc = p_addr[AUTO_CLOSE_BIT];
                        end
                        CODE_OPEN: s_d.cmd = SDCD_OPEN;
                        CODE_WRITE, CODE_READ: begin
                            // Bank, column; A13 ignored
                            s_d.cmd  = (code == CODE_WRITE) ? SDCD_WRITE : SDCD_READ;
                            s_d.ac   = p_addr[AUTO_CLOSE_BIT];
                            s_d.chop = (b_len == BEATS4_CYC);
                            s_d.addr[RESERVED_BIT] = 1'b0;
                            b_start  = !b_busy;
                        end
                        CODE_CAL: begin
                            s_d.cmd  = SDCD_CAL;
                            s_d.lcal = p_addr[AUTO_CLOSE_BIT];
                        end
                        CODE_IDLE: s_d.cmd = SDCD_NONE;
                    endcase
                end
            end
            default: s_d.pwr = SDCD_AWAKE;
        endcase
        // Termination pin never decodes; dead in self recharge
        s_d.term = p_term && (s_d.pwr != SDCD_SELF);
        if (!p_rst_n) begin
            // Device reset pin
            s_d.pwr = SDCD_AWAKE;
            s_d.cmd = SDCD_NONE;
            s_d.mr0 = '0;
        end
    end

    // Register
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q          <= '0;
            s_q.m1       <= PIN_IDLE;
            s_q.m2       <= PIN_IDLE;
            s_q.cke_prev <= 1'b1;
            s_q.pwr      <= SDCD_AWAKE;
            s_q.cmd      <= SDCD_NONE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign cmd                = s_q.cmd;
    assign cmd_bank           = s_q.bank;
    assign cmd_addr           = s_q.addr;
    assign all_rows_close_cmd = s_q.allc;
    assign long_impedance_cal = s_q.lcal;
    assign auto_close_flag    = s_q.ac;
    assign chopped_four_burst = s_q.chop;
    assign pwr_state          = s_q.pwr;
    assign burst_busy         = b_busy;
    assign burst_close        = b_close;
    assign termination_on     = s_q.term;
    assign mode_reg0          = s_q.mr0;
endmodule

// File: sdcd_pkg.sv
package sdcd_pkg;
    // Field widths
    localparam int BANK_W = 3;   // Bank select width
    localparam int ADDR_W = 14;  // Address width
    localparam int OP_W   = 16;  // Opcode field width

    // Address bit positions
    localparam int AUTO_CLOSE_BIT = 10;  // Auto close / all banks / long cal
    localparam int BURST_CHOP_BIT = 12;  // burst_chop_n
    localparam int RESERVED_BIT   = 13;  // reserved_bit

    // Mode register index and two-bit field for on-the-fly burst select
    localparam logic [BANK_W-1:0] MODE_REG0   = 3'h0;
    localparam int                OTF_SEL_LO  = 0;  // Burst field low bit
    localparam logic [1:0]        BURST_OTF   = 2'h1;  // Per-command burst code
    localparam logic [1:0]        BURST_FIX4  = 2'h2;  // Fixed four-beat code

    // Burst lengths in clock cycles (two beats per clock)
    localparam logic [2:0] BEATS8_CYC = 3'h4;
    localparam logic [2:0] BEATS4_CYC = 3'h2;

    // Least cycles after self-recharge exit before a write
    localparam int unsigned          SR_EXIT_WAIT_NCK = 512;
    localparam logic [9:0]           SR_EXIT_WAIT     = 10'(SR_EXIT_WAIT_NCK);

    // Strobe codes {row, column, write} with select low
    localparam logic [2:0] CODE_LOAD   = 3'h0;
    localparam logic [2:0] CODE_RECHG  = 3'h1;
    localparam logic [2:0] CODE_CLOSE  = 3'h2;
    localparam logic [2:0] CODE_OPEN   = 3'h3;
    localparam logic [2:0] CODE_WRITE  = 3'h4;
    localparam logic [2:0] CODE_READ   = 3'h5;
    localparam logic [2:0] CODE_CAL    = 3'h6;
    localparam logic [2:0] CODE_IDLE   = 3'h7;

    // Device power state, one-hot
    typedef enum logic [2:0] {
        SDCD_AWAKE = 3'h1,
        SDCD_SLEEP = 3'h2,
        SDCD_SELF  = 3'h4
    } sdcd_pwr_t;

    // Decoded command kinds, one-hot
    typedef enum logic [11:0] {
        SDCD_NONE   = 12'h001,
        SDCD_LOAD   = 12'h002,
        SDCD_RECHG  = 12'h004,
        SDCD_SRE    = 12'h008,
        SDCD_SRX    = 12'h010,
        SDCD_SLPIN  = 12'h020,
        SDCD_SLPOUT = 12'h040,
        SDCD_OPEN   = 12'h080,
        SDCD_CLOSE  = 12'h100,
        SDCD_WRITE  = 12'h200,
        SDCD_READ   = 12'h400,
        SDCD_CAL    = 12'h800
    } sdcd_cmd_t;
endpackage

// File: sdcd_if.sv
`timescale 1ns/1ps
// Command pins between controller and memory
interface sdcd_if;
    logic                        cke;          // Clock enable
    logic                        cs_n;         // Chip select
    logic                        ras_n;        // Row strobe
    logic                        cas_n;        // Column strobe
    logic                        we_n;         // Write enable
    logic [sdcd_pkg::BANK_W-1:0] bank;         // Bank select
    logic [sdcd_pkg::ADDR_W-1:0] addr;         // Address
    logic                        termination_control; // Termination pin
    logic                        rst_n;        // Device reset, active low

    modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, bank, addr, termination_control, rst_n);
    modport mem  (input  cke, cs_n, ras_n, cas_n, we_n, bank, addr, termination_control, rst_n);
endinterface

// File: sdcd_burst.sv
`timescale 1ns/1ps
// Burst runner: once started a burst runs to its end
module sdcd_burst
    import sdcd_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    // Start request
    input  wire logic       start,
    input  wire logic [2:0] len_cyc,
    input  wire logic       auto_close,
    // Status
    output logic            busy,
    output logic            close_pulse
);
    // All state
    typedef struct packed {
        logic [2:0] cnt;    // Cycles left
        logic       ac;     // Close row at end
        logic       close;  // Close pulse
    } sdcd_burst_st_t;

    sdcd_burst_st_t s_q, s_d;

    // Next state
    always_comb begin
        s_d = s_q;
        s_d.close = 1'b0;
        if (s_q.cnt != 3'h0) begin
            // Count down; nothing aborts the burst
            s_d.cnt = s_q.cnt - 3'h1;
            if (s_q.cnt == 3'h1) begin
                s_d.close = s_q.ac;
            end
        end else if (start) begin
            s_d.cnt = len_cyc;
            s_d.ac  = auto_close;
        end
    end

    // Register
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy        = (s_q.cnt != 3'h0);
    assign close_pulse = s_q.close;
endmodule

// File: sdcd_ctrl.sv
`timescale 1ns/1ps
// Controller end: drives one command per request, idle otherwise
module sdcd_ctrl
    import sdcd_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    // User request
    input  wire logic              req,
    input  wire logic              req_cke,
    input  wire logic [2:0]        req_code,
    input  wire logic [BANK_W-1:0] req_bank,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic              req_term,
    output logic                   req_ready,
    // Pins
    sdcd_if.ctrl                   pins
);
    // All state
    typedef struct packed {
        logic              cke;
        logic              cs_n;       // Deselect
        logic [2:0]        code;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
        logic              term;
        logic              was_self;   // In self recharge
        logic [9:0]        wait_cnt;   // Write hold-off after self exit
    } sdcd_ctrl_st_t;

    sdcd_ctrl_st_t s_q, s_d;
    logic is_write;

    assign is_write  = req_cke && (req_code == CODE_WRITE);
    // Hold writes off after self exit
    assign req_ready = !(is_write && s_q.wait_cnt != 10'h0);

    // Next state
    always_comb begin
        s_d      = s_q;
        s_d.code = CODE_IDLE;  // Idle between commands
        s_d.cs_n = 1'b0;
        s_d.bank = '0;         // Defined levels
        s_d.addr = '0;
        s_d.term = req_term;
        if (s_q.wait_cnt != 10'h0) begin
            s_d.wait_cnt = s_q.wait_cnt - 10'h1;
        end
        if (req && req_ready) begin
            s_d.cke  = req_cke;
            s_d.code = req_code;  // Caller sends legal codes
            s_d.bank = req_bank;
            s_d.addr = req_addr;
            if (req_code == CODE_IDLE) begin
                // Requested idle goes out as deselect, strobes parked low
                s_d.cs_n = 1'b1;
                s_d.code = CODE_LOAD;
            end
            if (!req_cke && req_code == CODE_RECHG) begin
                s_d.was_self = 1'b1;
            end
            if (req_cke && !s_q.cke && s_q.was_self) begin
                s_d.was_self = 1'b0;
                s_d.wait_cnt = SR_EXIT_WAIT;
                s_d.code     = CODE_IDLE;
            end
        end
    end

    // Register
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q      <= '0;
            s_q.cke  <= 1'b1;
            s_q.code <= CODE_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Pin drive
    assign pins.rst_n = 1'b1;  // Held high in operation
    assign pins.cke   = s_q.cke;
    assign pins.cs_n  = s_q.cs_n;
    assign {pins.ras_n, pins.cas_n, pins.we_n} = s_q.code;
    assign pins.bank  = s_q.bank;
    assign pins.addr  = s_q.addr;
    assign pins.termination_control = s_q.term;
endmodule

// File: sdcd_sva.sv
`timescale 1ns/1ps
// Watches the command pins and the decoded outputs of the memory end
module sdcd_sva
    import sdcd_pkg::*;
(
    // Clock and reset
    input logic              mclk,
    input logic              sys_rst,
    // Command pins
    input logic              cke,
    input logic              cs_n,
    input logic              ras_n,
    input logic              cas_n,
    input logic              we_n,
    input logic [ADDR_W-1:0] addr,
    // Decoded outputs
    input sdcd_cmd_t         cmd,
    input logic [ADDR_W-1:0] cmd_addr,
    input logic              all_rows_close_cmd,
    input logic              long_impedance_cal,
    input sdcd_pwr_t         pwr_state,
    input logic              burst_busy,
    input logic              termination_on
);
    default clocking dc @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // Strobe code and awake-and-selected qualifier
    wire [2:0] code  = {ras_n, cas_n, we_n};
    wire       awake = (pwr_state == SDCD_AWAKE) && !cs_n;

    // Command decode, three edges after the pins
    a_read_decode: assert property (awake && code == CODE_READ && cke && $past(cke) |-> ##3 cmd == SDCD_READ)
        else $error("read not decoded");
    a_write_decode: assert property (awake && code == CODE_WRITE && cke && $past(cke) |-> ##3 cmd == SDCD_WRITE)
        else $error("write not decoded");
    a_load_decode: assert property (awake && code == CODE_LOAD && cke && $past(cke) |-> ##3 cmd == SDCD_LOAD)
        else $error("mode load not decoded");
    a_close_scope: assert property (awake && code == CODE_CLOSE && cke && $past(cke)
        |-> ##3 cmd == SDCD_CLOSE && all_rows_close_cmd == $past(addr[AUTO_CLOSE_BIT], 3))
        else $error("row close scope wrong");
    a_cal_kind: assert property (awake && code == CODE_CAL && cke && $past(cke)
        |-> ##3 cmd == SDCD_CAL && long_impedance_cal == $past(addr[AUTO_CLOSE_BIT], 3))
        else $error("calibration kind wrong");
    a_idle_none: assert property ((cs_n || code == CODE_IDLE) && cke && $past(cke) |-> ##3 cmd == SDCD_NONE)
        else $error("idle decoded as a command");
    // Clock enable falling edges
    a_sleep_entry: assert property (pwr_state == SDCD_AWAKE && $fell(cke) && (cs_n || code == CODE_IDLE)
        |-> ##3 cmd == SDCD_SLPIN)
        else $error("sleep entry missed");
    a_self_entry: assert property (awake && $fell(cke) && code == CODE_RECHG |-> ##3 cmd == SDCD_SRE)
        else $error("self recharge entry missed");
    // Burst and status relations
    a_burst_whole: assert property ($rose(burst_busy) |-> burst_busy [*2])
        else $error("burst cut short");
    a_self_term: assert property (pwr_state == SDCD_SELF && $past(pwr_state) == SDCD_SELF |-> !termination_on)
        else $error("termination on in self recharge");
    a_rw_reserved: assert property (cmd == SDCD_READ || cmd == SDCD_WRITE |-> cmd_addr[RESERVED_BIT] == 1'b0)
        else $error("reserved address bit passed");
endmodule

// File: sdram_command_decoder_test.sv
`timescale 1ns/1ps
// Drives the controller end and checks what the memory end decodes
module sdram_command_decoder_test
    import sdcd_pkg::*;
;
    // Stimulus and observed signals
    logic              mclk, sys_rst, req, req_cke, req_term, req_ready, hit;
    logic [2:0]        req_code;
    logic [BANK_W-1:0] req_bank, cmd_bank;
    logic [ADDR_W-1:0] req_addr, cmd_addr;
    logic              all_rows_close_cmd, long_impedance_cal, auto_close_flag, chopped_four_burst;
    logic              burst_busy, burst_close, termination_on;
    logic [OP_W-1:0]   mode_reg0;
    sdcd_cmd_t         cmd;
    sdcd_pwr_t         pwr_state;
    int                num_errors = 0;
    int                checks = 0;
    int                cycles = 0;
    int                n;
    // Decode table: code, address, expected command
    logic [2:0]        t_code [9] = '{CODE_LOAD, CODE_RECHG, CODE_CLOSE, CODE_CLOSE, CODE_OPEN,
                                     CODE_CAL, CODE_CAL, CODE_WRITE, CODE_READ};
    logic [ADDR_W-1:0] t_addr [9] = '{14'h0005, 14'h0000, 14'h0000, 14'h0400, 14'h1234,
                                     14'h0400, 14'h0000, 14'h3400, 14'h2400};
    sdcd_cmd_t         t_cmd  [9] = '{SDCD_LOAD, SDCD_RECHG, SDCD_CLOSE, SDCD_CLOSE, SDCD_OPEN,
                                     SDCD_CAL, SDCD_CAL, SDCD_WRITE, SDCD_READ};

    sdcd_if link();
    sdcd_ctrl u_sdcd_ctrl (.mclk(mclk), .sys_rst(sys_rst), .req(req), .req_cke(req_cke), .req_code(req_code),
        .req_bank(req_bank), .req_addr(req_addr), .req_term(req_term), .req_ready(req_ready), .pins(link));
    sdcd_mem u_sdcd_mem (.mclk(mclk), .sys_rst(sys_rst), .pins(link), .cmd(cmd), .cmd_bank(cmd_bank),
        .cmd_addr(cmd_addr), .all_rows_close_cmd(all_rows_close_cmd), .long_impedance_cal(long_impedance_cal),
        .auto_close_flag(auto_close_flag), .chopped_four_burst(chopped_four_burst), .pwr_state(pwr_state),
        .burst_busy(burst_busy), .burst_close(burst_close), .termination_on(termination_on), .mode_reg0(mode_reg0));
    sdcd_sva u_sdcd_sva (.mclk(mclk), .sys_rst(sys_rst), .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
        .cas_n(link.cas_n), .we_n(link.we_n), .addr(link.addr), .cmd(cmd), .cmd_addr(cmd_addr),
        .all_rows_close_cmd(all_rows_close_cmd), .long_impedance_cal(long_impedance_cal),
        .pwr_state(pwr_state), .burst_busy(burst_busy), .termination_on(termination_on));

    // Clock, 20 ns period
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Hang guard
    initial begin
        while (cycles < 3000) begin
            @(posedge mclk);
            cycles++;
        end
        num_errors++;
        print_verdict();
    end

    // Counts, verdict and end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Compare seen against expected
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Present one request and hold it until taken
    task automatic send(input logic ck, input logic [2:0] code, input logic [2:0] bk,
                        input logic [ADDR_W-1:0] a, input logic t);
        int w;
        @(negedge mclk);
        req = 1'b1;
        req_cke = ck;
        req_code = code;
        req_bank = bk;
        req_addr = a;
        req_term = t;
        #2;
        w = 0;
        while (req_ready !== 1'b1 && w < 600) begin
            @(negedge mclk);
            w++;
        end
        check("taken", (w < 600), 1'b1);
        @(posedge mclk);
    endtask

    // Release the request, then wait for a decoded command
    task automatic wait_cmd(input sdcd_cmd_t exp);
        int k;
        @(negedge mclk);
        req = 1'b0;
        hit = 1'b0;
        for (k = 0; k < 10 && !hit; k++) begin
            @(posedge mclk);
            #1;
            hit = (cmd === exp);
        end
        check("cmd", cmd, exp);
    endtask

    // Count burst busy cycles from now
    task automatic burst_len(input int exp);
        int c;
        c = 0;
        while (burst_busy === 1'b1 && c < 12) begin
            @(posedge mclk);
            #1;
            c++;
        end
        check("burst", c, exp);
    endtask

    // Idle gap
    task automatic rest(input int c);
        repeat (c) @(posedge mclk);
    endtask

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        req = 1'b0;
        req_cke = 1'b1;
        req_code = CODE_IDLE;
        req_bank = 3'h0;
        req_addr = 14'h0000;
        req_term = 1'b0;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        sys_rst = 1'b0;
        check("cmd", cmd, SDCD_NONE);
        check("pwr", pwr_state, SDCD_AWAKE);
        check("cke", link.cke, 1'b1);
        check("rst", link.rst_n, 1'b1);
        $display("test reset done");
        // Every command code, termination high throughout
        for (int i = 0; i < 9; i++) begin
            send(1'b1, t_code[i], 3'h1, t_addr[i], 1'b1);
            wait_cmd(t_cmd[i]);
            check("term", termination_on, 1'b1);
            check("idle", {link.ras_n, link.cas_n, link.we_n}, CODE_IDLE);
            check("addr0", link.addr, 14'h0000);
            if (t_code[i] == CODE_CLOSE) check("all", all_rows_close_cmd, t_addr[i][10]);
            if (t_code[i] == CODE_CAL) check("long", long_impedance_cal, t_addr[i][10]);
            if (t_code[i] == CODE_WRITE || t_code[i] == CODE_READ) begin
                check("addr", cmd_addr, t_addr[i] & 14'h1FFF);
                check("bank", cmd_bank, 3'h1);
                check("close", auto_close_flag, t_addr[i][10]);
                burst_len(4);
            end
            rest(6);
        end
        check("mode", mode_reg0, 16'h0000);
        $display("test decode done");
        // Per-command burst length, back-to-back reads, auto close
        send(1'b1, CODE_LOAD, 3'h0, 14'h0001, 1'b0);
        wait_cmd(SDCD_LOAD);
        rest(2);
        check("mode", mode_reg0, 16'h0001);
        send(1'b1, CODE_READ, 3'h2, 14'h0000, 1'b0);
        wait_cmd(SDCD_READ);
        check("chop", chopped_four_burst, 1'b1);
        burst_len(2);
        rest(4);
        send(1'b1, CODE_READ, 3'h2, 14'h1000, 1'b0);
        send(1'b1, CODE_READ, 3'h2, 14'h1008, 1'b0);
        wait_cmd(SDCD_READ);
        burst_len(4);
        rest(6);
        send(1'b1, CODE_WRITE, 3'h2, 14'h1400, 1'b0);
        wait_cmd(SDCD_WRITE);
        hit = 1'b0;
        repeat (8) begin
            @(posedge mclk);
            #1;
            hit = hit | (burst_close === 1'b1);
        end
        check("autoclose", hit, 1'b1);
        $display("test burst done");
        // Sleep entry and exit
        send(1'b0, CODE_IDLE, 3'h0, 14'h0000, 1'b0);
        wait_cmd(SDCD_SLPIN);
        rest(2);
        check("pwr", pwr_state, SDCD_SLEEP);
        send(1'b1, CODE_IDLE, 3'h0, 14'h0000, 1'b0);
        wait_cmd(SDCD_SLPOUT);
        rest(2);
        check("pwr", pwr_state, SDCD_AWAKE);
        $display("test sleep done");
        // Self recharge, then the write lockout after exit
        send(1'b0, CODE_RECHG, 3'h0, 14'h0000, 1'b1);
        wait_cmd(SDCD_SRE);
        rest(3);
        check("pwr", pwr_state, SDCD_SELF);
        check("term", termination_on, 1'b0);
        send(1'b1, CODE_IDLE, 3'h0, 14'h0000, 1'b0);
        @(negedge mclk);
        req_code = CODE_WRITE;
        #2;
        check("ready", req_ready, 1'b0);
        n = 1;
        while (req_ready !== 1'b1 && n < 600) begin
            @(negedge mclk);
            #2;
            n++;
        end
        check("lockout", (n >= 508 && n <= 516), 1'b1);
        @(posedge mclk);
        wait_cmd(SDCD_WRITE);
        check("pwr", pwr_state, SDCD_AWAKE);
        $display("test self done");
        rest(6);
        print_verdict();
    end
endmodule
